// >>> scm_pkg.sv
// Overview of operation
// RL1 - Reset always starts on the internal RC oscillator
// RL2 - External 4-16 MHz clock selectable, watched continuously
// RL3 - External clock failure falls back to RC automatically
// RL4 - Clock failure interrupt only when enabled
// RL5 - PLL entry has its own failure interrupt
// RL6 - Separate prescalers for main, fast, slow buses
// RL7 - Software keeps main and fast bus within 72 MHz
// RL8 - Software keeps slow bus within 36 MHz
// RL9 - Failure flag sticky; switching never truncates pulses
`default_nettype none
package scm_pkg;
    // Clock sources
    typedef enum logic [1:0] {
        SCM_SRC_RC,
        SCM_SRC_EXT,
        SCM_SRC_PLL,
        SCM_SRC_RSVD
    } scm_src_e;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF     = 8'h00;
    localparam logic [7:0] PRESC_OFF    = 8'h04;
    localparam logic [7:0] STATUS_OFF   = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h10;

    // Field positions
    localparam int SRC_REQ_LSB   = 0;
    localparam int MAIN_DIV_LSB  = 0;
    localparam int FAST_DIV_LSB  = 4;
    localparam int SLOW_DIV_LSB  = 8;
    localparam int ACT_SRC_LSB   = 0;
    localparam int EXT_OK_BIT    = 2;
    localparam int PLL_LOCK_BIT  = 3;
    localparam int SW_PEND_BIT   = 4;
    localparam int EXT_FAIL_BIT  = 0;
    localparam int PLL_FAIL_BIT  = 1;
    localparam int SW_DONE_BIT   = 2;
    localparam int IRQ_BITS      = 3;
    localparam int DIV_W         = 3;

    // Reset values
    localparam logic [31:0] PRESC_RST    = 32'h0000_0000;
    localparam logic [2:0]  IRQ_MASK_RST = 3'h0;

    // Timing
    localparam int REF_CLK_KHZ     = 25000;
    localparam int EXT_TIMEOUT_NS  = 640;
    localparam int EXT_TIMEOUT_CYC = (EXT_TIMEOUT_NS * REF_CLK_KHZ) / 1000000;
    localparam int TMO_W           = 5;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : scm_pkg
`default_nettype wire

// >>> scm_clock_select_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module scm_clock_select_monitor (
    input  wire logic        ref_clk,    // 25 MHz block clock
    input  wire logic        srst,       // Synchronous reset, high
    input  wire logic        extClkIn,   // External oscillator, asynchronous
    input  wire logic        pllLockIn,  // PLL lock, asynchronous
    input  wire logic [7:0]  awaddr,     // AXI write address
    input  wire logic        awvalid,    // AXI write address valid
    output logic             awready,    // AXI write address ready
    input  wire logic [31:0] wdata,      // AXI write data
    input  wire logic [3:0]  wstrb,      // AXI write strobes
    input  wire logic        wvalid,     // AXI write data valid
    output logic             wready,     // AXI write data ready
    output logic [1:0]       bresp,      // AXI write response
    output logic             bvalid,     // AXI write response valid
    input  wire logic        bready,     // AXI write response ready
    input  wire logic [7:0]  araddr,     // AXI read address
    input  wire logic        arvalid,    // AXI read address valid
    output logic             arready,    // AXI read address ready
    output logic [31:0]      rdata,      // AXI read data
    output logic [1:0]       rresp,      // AXI read response
    output logic             rvalid,     // AXI read valid
    input  wire logic        rready,     // AXI read ready
    output logic [1:0]       sysClkSrc,  // Active system clock source
    output logic             mainTick,   // Main bus clock enable
    output logic             fastTick,   // Fast peripheral bus enable
    output logic             slowTick,   // Slow peripheral bus enable
    output logic             irq         // Level interrupt
);
    localparam int TMO = scm_pkg::EXT_TIMEOUT_CYC;

    logic [2:0] extSync_reg;
    logic [1:0] pllSync_reg;
    logic [scm_pkg::TMO_W-1:0] tmo_reg;
    logic extOk_reg;
    logic extEdge;
    logic pllLockPrev_reg;

    scm_pkg::scm_src_e srcReq_reg;
    scm_pkg::scm_src_e actSrc_reg;
    logic [11:0] presc_reg;
    logic [scm_pkg::IRQ_BITS-1:0] irqStat_reg;
    logic [scm_pkg::IRQ_BITS-1:0] irqMask_reg;
    logic [scm_pkg::IRQ_BITS-1:0] irqSet;
    logic extFail;
    logic pllFail;
    logic swDone;
    logic baseTick;
    logic [2:0] domTick;
    logic [2:0] srcTick;

    logic wrFire;
    logic rdFire;
    logic [31:0] rdMux;
    logic rdHit;
    logic wrHit;

    // Pin synchronisers; edge detect uses stages two and three only
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            extSync_reg <= 3'h0;
            pllSync_reg <= 2'h0;
        end else begin
            extSync_reg <= {extSync_reg[1:0], extClkIn};
            pllSync_reg <= {pllSync_reg[0], pllLockIn};
        end
    end
    assign extEdge = extSync_reg[1] & ~extSync_reg[2];

    // Missing-edge monitor: 4 MHz gives an edge every 6.25 cycles, so a
    // gap of the timeout means the oscillator has stopped
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tmo_reg   <= '0;
            extOk_reg <= 1'b0;
        end else if (extEdge) begin
            tmo_reg   <= '0;
            extOk_reg <= 1'b1;
        end else if (int'(tmo_reg) >= TMO - 1) begin
            extOk_reg <= 1'b0;
        end else begin
            tmo_reg <= tmo_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pllLockPrev_reg <= 1'b0;
        end else begin
            pllLockPrev_reg <= pllSync_reg[1];
        end
    end

    assign extFail = (actSrc_reg == scm_pkg::SCM_SRC_EXT) && !extOk_reg;          // RL2
    assign pllFail = (actSrc_reg == scm_pkg::SCM_SRC_PLL) && pllLockPrev_reg
                     && !pllSync_reg[1];                                            // RL5
    assign swDone  = (srcReq_reg != actSrc_reg) && domTick[0] && !extFail && !pllFail;

    // Base tick of the running source; the oscillator is seen through its edges
    always_comb begin
        unique case (actSrc_reg)
            scm_pkg::SCM_SRC_EXT: baseTick = extEdge;
            default:              baseTick = 1'b1;
        endcase
    end

    // Prescalers; fast and slow count main ticks, ratio 2^n, n in 0..7
    assign srcTick = {domTick[0], domTick[0], baseTick};
    generate
        for (genvar d = 0; d < 3; d++) begin : g_presc
            logic [7:0] cnt_reg;
            logic [scm_pkg::DIV_W-1:0] div;
            logic [7:0] lim;
            assign div = presc_reg[4*d +: scm_pkg::DIV_W];
            assign lim = 8'((9'h1 << div) - 9'h1);
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    cnt_reg <= 8'h00;
                end else if (srcTick[d]) begin
                    cnt_reg <= (cnt_reg >= lim) ? 8'h00 : cnt_reg + 8'h01;       // RL6
                end
            end
            assign domTick[d] = srcTick[d] && (cnt_reg >= lim);
        end
    endgenerate

    // Outputs registered so a source change never cuts a pulse short
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mainTick <= 1'b0;
            fastTick <= 1'b0;
            slowTick <= 1'b0;
        end else begin
            mainTick <= domTick[0];
            fastTick <= domTick[1];
            slowTick <= domTick[2];
        end
    end

    // Source switch: only at a main bus period boundary; failure is immediate
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            actSrc_reg <= scm_pkg::SCM_SRC_RC;                                   // RL1
        end else if (extFail || pllFail) begin
            actSrc_reg <= scm_pkg::SCM_SRC_RC;                                   // RL3
        end else if (swDone) begin
            actSrc_reg <= srcReq_reg;                                            // RL9
        end
    end
    assign sysClkSrc = actSrc_reg;

    // Bus slave: write address and data taken together, one response open
    assign awready = awvalid && wvalid && !bvalid;
    assign wready  = awready;
    assign wrFire  = awready;
    assign arready = !rvalid;
    assign rdFire  = arvalid && arready;

    always_comb begin
        wrHit = 1'b1;
        unique case (awaddr)
            scm_pkg::CTRL_OFF, scm_pkg::PRESC_OFF, scm_pkg::STATUS_OFF,
            scm_pkg::IRQ_STAT_OFF, scm_pkg::IRQ_MASK_OFF: wrHit = 1'b1;
            default: wrHit = 1'b0;
        endcase
    end

    // Hardware fallback overrides a same-cycle software request
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            srcReq_reg <= scm_pkg::SCM_SRC_RC;                                   // RL1
        end else if (extFail || pllFail) begin
            srcReq_reg <= scm_pkg::SCM_SRC_RC;                                   // RL3
        end else if (wrFire && awaddr == scm_pkg::CTRL_OFF && wstrb[0]
                     && wdata[1:0] != 2'h3) begin
            srcReq_reg <= scm_pkg::scm_src_e'(wdata[1:0]);                       // RL2
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            presc_reg <= scm_pkg::PRESC_RST[11:0];
        end else if (wrFire && awaddr == scm_pkg::PRESC_OFF) begin
            if (wstrb[0]) presc_reg[7:0]  <= wdata[7:0];                         // RL6
            if (wstrb[1]) presc_reg[11:8] <= wdata[11:8];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irqMask_reg <= scm_pkg::IRQ_MASK_RST;
        end else if (wrFire && awaddr == scm_pkg::IRQ_MASK_OFF && wstrb[0]) begin
            irqMask_reg <= wdata[scm_pkg::IRQ_BITS-1:0];                         // RL4
        end
    end

    // Sticky events; a new event beats a write-one-to-clear
    assign irqSet = {swDone, pllFail, extFail};
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irqStat_reg <= '0;
        end else if (wrFire && awaddr == scm_pkg::IRQ_STAT_OFF && wstrb[0]) begin
            irqStat_reg <= (irqStat_reg & ~wdata[scm_pkg::IRQ_BITS-1:0]) | irqSet; // RL9
        end else begin
            irqStat_reg <= irqStat_reg | irqSet;                                 // RL9
        end
    end
    assign irq = |(irqStat_reg & irqMask_reg);                                   // RL4 RL5

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bvalid <= 1'b0;
            bresp  <= scm_pkg::AXI_OKAY;
        end else if (wrFire) begin
            bvalid <= 1'b1;
            bresp  <= wrHit ? scm_pkg::AXI_OKAY : scm_pkg::AXI_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        unique case (araddr)
            scm_pkg::CTRL_OFF:     rdMux[1:0] = srcReq_reg;
            scm_pkg::PRESC_OFF:    rdMux[11:0] = presc_reg;
            scm_pkg::STATUS_OFF: begin
                rdMux[1:0]                   = actSrc_reg;
                rdMux[scm_pkg::EXT_OK_BIT]   = extOk_reg;
                rdMux[scm_pkg::PLL_LOCK_BIT] = pllSync_reg[1];
                rdMux[scm_pkg::SW_PEND_BIT]  = srcReq_reg != actSrc_reg;
            end
            scm_pkg::IRQ_STAT_OFF: rdMux[scm_pkg::IRQ_BITS-1:0] = irqStat_reg;
            scm_pkg::IRQ_MASK_OFF: rdMux[scm_pkg::IRQ_BITS-1:0] = irqMask_reg;
            default:               rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= scm_pkg::AXI_OKAY;
        end else if (rdFire) begin
            rvalid <= 1'b1;
            rdata  <= rdMux;
            rresp  <= rdHit ? scm_pkg::AXI_OKAY : scm_pkg::AXI_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : scm_clock_select_monitor
`default_nettype wire

// >>> scm_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module scm_assertions (
    input wire logic        ref_clk,   // Clock
    input wire logic        srst,      // Reset
    input wire logic        extClkIn,  // Ext osc
    input wire logic        pllLockIn, // PLL lock
    input wire logic        awvalid,   // Write addr valid
    input wire logic        wvalid,    // Write data valid
    input wire logic        rvalid,    // Read valid
    input wire logic        rready,    // Read ready
    input wire logic [31:0] rdata,     // Read data
    input wire logic [1:0]  sysClkSrc, // Active source
    input wire logic        mainTick,  // Main tick
    input wire logic        fastTick,  // Fast tick
    input wire logic        slowTick,  // Slow tick
    input wire logic        irq        // Interrupt
);
    logic [5:0] stallCnt;
    logic       extLast;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Saturates so a long stop never wraps back under the limit
    always_ff @(posedge ref_clk) begin
        extLast <= extClkIn;
        if (srst || extClkIn != extLast) stallCnt <= 6'h00;
        else if (stallCnt != 6'h3F) stallCnt <= stallCnt + 6'h01;
    end
    sequence extDead; stallCnt > 6'h18 && sysClkSrc == 2'h1; endsequence
    sequence pllDrop; $fell(pllLockIn) && sysClkSrc == 2'h2; endsequence
    chk_reset_rc: assert property (disable iff (1'b0) srst |=> sysClkSrc == 2'h0 && !irq)
        else $error("source or irq wrong after reset");
    chk_ext_fallback: assert property (extDead |=> sysClkSrc == 2'h0)
        else $error("no fallback from dead external clock");
    chk_pll_fallback: assert property (pllDrop |-> ##[1:6] sysClkSrc == 2'h0)
        else $error("no fallback from lost PLL");
    chk_irq_sticky: assert property (irq && !(awvalid && wvalid) |=> irq)
        else $error("irq dropped without a write");
    chk_fast_main: assert property (fastTick |-> mainTick)
        else $error("fast tick off the main tick");
    chk_slow_main: assert property (slowTick |-> mainTick)
        else $error("slow tick off the main tick");
    chk_src_legal: assert property (sysClkSrc != 2'h3)
        else $error("reserved source active");
    chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer not held");
endmodule : scm_assertions
`default_nettype wire

// >>> scm_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module scm_osc_model (
    input  wire logic extRun,  // Oscillator on
    input  wire logic pllRun,  // PLL on
    output var logic  extClk,  // Oscillator pin
    output var logic  pllLock  // Lock flag
);
    initial extClk = 1'b0;
    initial pllLock = 1'b0;
    // 6.25 MHz; a stopped oscillator holds its last level
    always #80 if (extRun) extClk = ~extClk;
    // Odd delay keeps lock edges away from the sampling clock edges
    always @(pllRun) pllLock <= #210 pllRun;
endmodule : scm_osc_model
`default_nettype wire

// >>> scm_clock_select_monitor_bench.sv
`timescale 1ns/1ps
`default_nettype none
module scm_clock_select_monitor_bench;
    logic        ref_clk = 0, srst = 1, extRun = 0, pllRun = 0, extClkIn, pllLockIn;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, mainTick, fastTick, slowTick, irq;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp, sysClkSrc;
    logic [33:0] expQ[$];
    int          fail_count = 0, check_count = 0, n, dm, df, ds;
    always #20 ref_clk = ~ref_clk;
    scm_clock_select_monitor dut_u (.ref_clk, .srst, .extClkIn, .pllLockIn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .sysClkSrc, .mainTick, .fastTick, .slowTick,
        .irq);
    scm_osc_model osc_u (.extRun, .pllRun, .extClk(extClkIn), .pllLock(pllLockIn));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bound(input int k);
        if (k >= 100) begin
            fail_count++;
            print_verdict();
        end
    endtask : bound
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ad, wd;
        ad = 0;
        wd = 0;
        expQ.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        for (n = 0; n < 100 && !(ad && wd); n++) begin
            @(posedge ref_clk);
            ad = ad | awready;
            wd = wd | wready;
            awvalid <= !ad;
            wvalid <= !wd;
        end
        bound(n);
        // Ready rises only after the take, so back-to-back calls never touch it twice in one step
        bready <= 1;
        @(posedge ref_clk);
        for (n = 0; n < 100 && !bvalid; n++) @(posedge ref_clk);
        bound(n);
        bready <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        expQ.push_back(e);
        araddr <= a;
        arvalid <= 1;
        @(posedge ref_clk);
        for (n = 0; n < 100 && !arready; n++) @(posedge ref_clk);
        bound(n);
        arvalid <= 0;
        // Ready one cycle late so the answer must hold while it waits
        @(posedge ref_clk);
        rready <= 1;
        @(posedge ref_clk);
        for (n = 0; n < 100 && !rvalid; n++) @(posedge ref_clk);
        bound(n);
        rready <= 0;
    endtask : rd
    // Responses are judged here, in the order the requests were made
    always @(posedge ref_clk) begin
        if ((bvalid && bready) || (rvalid && rready))
            check("bus answer", bvalid ? {bresp, 32'h0} : {rresp, rdata}, expQ.pop_front());
    end
    function automatic logic tk(input int w);
        return w == 0 ? mainTick : (w == 1 ? fastTick : slowTick);
    endfunction : tk
    // Skips two ticks first, since a divider change may leave a short period
    task automatic gap(input int w, input int e);
        int c;
        repeat (2) begin
            for (n = 0; n < 100 && !tk(w); n++) @(posedge ref_clk);
            bound(n);
            @(posedge ref_clk);
        end
        for (c = 1; c < 100 && !tk(w); c++) @(posedge ref_clk);
        check("tick gap", 34'(c), 34'(e));
    endtask : gap
    task automatic waitSrc(input logic [1:0] s);
        for (n = 0; n < 100 && sysClkSrc !== s; n++) @(posedge ref_clk);
        bound(n);
    endtask : waitSrc
    initial begin
        void'($urandom(96));
        dm = $urandom % 4;
        df = $urandom % 3;
        ds = $urandom % 3;
        repeat (2) @(posedge ref_clk);
        srst <= 0;
        rd(scm_pkg::STATUS_OFF, 34'h0);
        rd(scm_pkg::IRQ_MASK_OFF, 34'h0);
        rd(8'h14, {scm_pkg::AXI_SLVERR, 32'h0});
        gap(0, 1);
        wr(scm_pkg::PRESC_OFF, 32'(ds * 256 + df * 16 + dm), scm_pkg::AXI_OKAY);
        gap(0, 1 << dm);
        gap(1, 1 << (dm + df));
        gap(2, 1 << (dm + ds));
        wr(scm_pkg::PRESC_OFF, 32'h0, scm_pkg::AXI_OKAY);
        extRun <= 1;
        repeat (30) @(posedge ref_clk);
        wr(scm_pkg::CTRL_OFF, 32'h1, scm_pkg::AXI_OKAY);
        waitSrc(2'h1);
        rd(scm_pkg::STATUS_OFF, 34'h5);
        wr(scm_pkg::IRQ_STAT_OFF, 32'h4, scm_pkg::AXI_OKAY);
        wr(scm_pkg::IRQ_MASK_OFF, 32'h1, scm_pkg::AXI_OKAY);
        check("irq idle", {33'h0, irq}, 34'h0);
        extRun <= 0;
        waitSrc(2'h0);
        repeat (20) @(posedge ref_clk);
        check("irq ext", {33'h0, irq}, 34'h1);
        wr(scm_pkg::IRQ_STAT_OFF, 32'h7, scm_pkg::AXI_OKAY);
        check("irq cleared", {33'h0, irq}, 34'h0);
        pllRun <= 1;
        repeat (20) @(posedge ref_clk);
        wr(scm_pkg::CTRL_OFF, 32'h2, scm_pkg::AXI_OKAY);
        waitSrc(2'h2);
        pllRun <= 0;
        waitSrc(2'h0);
        repeat (5) @(posedge ref_clk);
        check("irq masked", {33'h0, irq}, 34'h0);
        wr(scm_pkg::IRQ_MASK_OFF, 32'h2, scm_pkg::AXI_OKAY);
        check("irq pll", {33'h0, irq}, 34'h1);
        wr(scm_pkg::CTRL_OFF, 32'h1, scm_pkg::AXI_OKAY);
        repeat (5) @(posedge ref_clk);
        rd(scm_pkg::CTRL_OFF, 34'h0);
        wr(scm_pkg::CTRL_OFF, 32'h3, scm_pkg::AXI_OKAY);
        rd(scm_pkg::CTRL_OFF, 34'h0);
        srst <= 1;
        repeat (2) @(posedge ref_clk);
        srst <= 0;
        rd(scm_pkg::STATUS_OFF, 34'h0);
        check("irq reset", {33'h0, irq}, 34'h0);
        print_verdict();
    end
    initial begin
        #3600000;
        fail_count++;
        print_verdict();
    end
endmodule : scm_clock_select_monitor_bench
bind scm_clock_select_monitor scm_assertions chk_u (.ref_clk, .srst, .extClkIn, .pllLockIn,
    .awvalid, .wvalid, .rvalid, .rready, .rdata, .sysClkSrc, .mainTick, .fastTick, .slowTick,
    .irq);
`default_nettype wire
